// >>> hw/pdpc_pkg.sv
// Constants, types and ECC functions for the pre-driver protection and configuration block.
// Assumes one 10 MHz system clock that also serves as the internal timing reference.
// Function
// - Motor supply overvoltage always switches all gates off; nothing can mask it.
// - With drain-source compare disabled, drain-source events are ignored completely.
// - Compare on, trip off: drain-source event reported, gates stay active.
// - Compare and trip on: drain-source event reported and gates disabled.
// - Regulator overvoltage always reported; it tri-states gates only when trip enabled.
// - Protection shutdown holds gates off until end-of-frame report is acknowledged.
// - Gates off while logic supply or gate enable is low; released when high.
// - Configuration store corrects single-bit errors and detects double-bit errors.
// - Three-bit crossover delay sets dead time; default 011 gives 1.0 us.
// - Three-bit drain-source threshold selects monitor level; default 111.
// - Two-bit drain-source blanking sets ignore time after turn-on; default 10.
// - Three-bit shunt amplifier gain select; default 011 gives gain 17.2.
// - Boost reference select: 0 regulates to ground, 1 to supply; default 0; the code fixes the bit at 0 and serial writes force 0.
// - Serial port enable defaults 1; in serial mode only writable 1 to 0.
// - Gate undervoltage comparator enable, on at 1, default 0.
// - Fault PWM rate: 1 fast (default), 0 slow at 12.5 kHz.
// - Boost charge pump enable, on at 1, default 0.
// - Device enters serial mode only when all entry conditions and pulse are seen.
// - Enable rising in serial mode finishes writes, copies store, then normal mode.
// - Fault line held low while the configuration copy runs.
// - After reset and after serial mode, gates blocked until copy completes.
// - End-of-frame acknowledge clears latched errors except flags active in that cycle and idles fault line high.
// - Line sampled at each own PWM falling edge; low sample is an acknowledge.
package pdpc_pkg;

  // Clock and fault-line timing.
  localparam int CLK_PERIOD_NS = 100;
  localparam int FAST_PERIOD_NS = 10000;
  localparam int SLOW_FREQ_HZ = 12500;
  localparam int SLOW_PERIOD_NS = 1000000000 / SLOW_FREQ_HZ;
  localparam int FAST_CYC = FAST_PERIOD_NS / CLK_PERIOD_NS;
  localparam int SLOW_CYC = SLOW_PERIOD_NS / CLK_PERIOD_NS;
  localparam int ERR_DUTY_PERMILLE = 500;
  localparam int EOF_DUTY_PERMILLE = 935;
  localparam int PWM_W = 10;
  localparam logic [PWM_W-1:0] FAST_PER = PWM_W'(FAST_CYC);
  localparam logic [PWM_W-1:0] SLOW_PER = PWM_W'(SLOW_CYC);
  localparam logic [PWM_W-1:0] FAST_ERR_HI = PWM_W'(FAST_CYC * ERR_DUTY_PERMILLE / 1000);
  localparam logic [PWM_W-1:0] SLOW_ERR_HI = PWM_W'(SLOW_CYC * ERR_DUTY_PERMILLE / 1000);
  localparam logic [PWM_W-1:0] FAST_EOF_HI = PWM_W'(FAST_CYC * EOF_DUTY_PERMILLE / 1000);
  localparam logic [PWM_W-1:0] SLOW_EOF_HI = PWM_W'(SLOW_CYC * EOF_DUTY_PERMILLE / 1000);

  // Serial entry pulse window in clock periods.
  localparam int PULSE_W = 13;
  localparam logic [PULSE_W-1:0] ENTRY_MIN = 13'h0800;
  localparam logic [PULSE_W-1:0] ENTRY_MAX = 13'h1000;
  localparam logic [PULSE_W-1:0] PULSE_SAT = 13'h1001;

  // Register offsets.
  localparam int NWORDS = 6;
  localparam logic [2:0] ADDR_RSVD0 = 3'h0;
  localparam logic [2:0] ADDR_RSVD1 = 3'h1;
  localparam logic [2:0] ADDR_TIMING = 3'h2;
  localparam logic [2:0] ADDR_MONPWM = 3'h3;
  localparam logic [2:0] ADDR_PROT = 3'h4;
  localparam logic [2:0] ADDR_IFACE = 3'h5;

  // Field positions.
  localparam int DLY_LSB = 5;
  localparam int THR_LSB = 0;
  localparam int BLK_LSB = 6;
  localparam int PWMR_BIT = 5;
  localparam int GAIN_LSB = 1;
  localparam int BREF_BIT = 0;
  localparam int RTRIP_BIT = 7;
  localparam int DTRIP_BIT = 6;
  localparam int DCMP_BIT = 5;
  localparam int GUV_BIT = 4;
  localparam int PUMP_BIT = 2;
  localparam int SPEN_BIT = 7;

  // Values after reset and fixed bits per word.
  localparam logic [7:0] WORD_RESET [NWORDS] = '{8'h00, 8'h00, 8'h67, 8'hA6, 8'hE0, 8'hC0};
  localparam logic [7:0] FIXED_MASK [NWORDS] = '{8'hFF, 8'hFF, 8'h18, 8'h11, 8'h0B, 8'h7F};
  localparam logic [7:0] FIXED_VAL [NWORDS] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40};

  // Error latch positions.
  localparam int ERR_MOV = 0;
  localparam int ERR_DS = 1;
  localparam int ERR_REG = 2;
  localparam int ERR_EEP = 3;

  typedef enum logic [1:0] {
    PDPC_COPY = 2'b00,
    PDPC_NORMAL = 2'b01,
    PDPC_SERIAL = 2'b10,
    PDPC_FINISH = 2'b11
  } pdpc_mode_t;

  typedef enum logic [1:0] {
    PDPC_IDLE = 2'b00,
    PDPC_ERR = 2'b01,
    PDPC_EOF = 2'b10
  } pdpc_rep_t;

  typedef struct packed {
    logic [2:0] crossover_delay;
    logic [2:0] drain_source_threshold;
    logic [1:0] drain_source_blanking;
    logic [2:0] shunt_amp_gain;
    logic boost_reference_select;
    logic fault_pwm_rate;
    logic gate_undervolt_compare_enable;
    logic boost_pump_enable;
    logic drain_source_compare_enable;
    logic drain_source_trip_enable;
    logic regulator_overvolt_trip_enable;
    logic serial_port_enable;
  } pdpc_cfg_t;

  typedef struct packed {
    logic [7:0] data;
    logic ded;
  } pdpc_dec_t;

  // Hamming code over positions 1..12 with overall parity in bit 0.
  function automatic logic [12:0] pdpc_enc(input logic [7:0] d);
    logic [12:0] cw;
    int k;
    cw = '0;
    k = 0;
    for (int p = 3; p < 13; p++) begin
      if (p != 4 && p != 8) begin
        cw[p] = d[k];
        k++;
      end
    end
    for (int b = 0; b < 4; b++) begin
      for (int p = 3; p < 13; p++) begin
        if (p[b] && p != (1 << b)) begin
          cw[1 << b] = cw[1 << b] ^ cw[p];
        end
      end
    end
    cw[0] = ^cw[12:1];
    return cw;
  endfunction

  function automatic pdpc_dec_t pdpc_dec(input logic [12:0] cw_in);
    logic [12:0] cw;
    logic [3:0] syn;
    pdpc_dec_t r;
    int k;
    cw = cw_in;
    syn = 4'h0;
    r = '0;
    k = 0;
    for (int p = 1; p < 13; p++) begin
      if (cw[p]) begin
        syn = syn ^ 4'(p);
      end
    end
    if (syn != 4'h0 && !(^cw)) begin
      r.ded = 1'b1;
    end else if (syn != 4'h0 && syn < 4'hD) begin
      cw[syn] = ~cw[syn];
    end else if (syn != 4'h0) begin
      r.ded = 1'b1;
    end
    for (int p = 3; p < 13; p++) begin
      if (p != 4 && p != 8) begin
        r.data[k] = cw[p];
        k++;
      end
    end
    return r;
  endfunction

endpackage

// >>> hw/pdpc_top.sv
// Protection, fault-line handshake and configuration store of a three-phase gate pre-driver.
// Assumes pins and comparator flags are asynchronous and the serial port logic is on sys_clk.
`timescale 1ns/1ps
module pdpc_top
  import pdpc_pkg::*;
#(
  parameter int EEP_WRITE_CYCLES = 16
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_b,
  // Pins from the controller.
  input wire logic logic_supply_pin,
  input wire logic gate_enable_input,
  input wire logic [2:0] high_side_input,
  input wire logic [2:0] low_side_input,
  input wire logic fault_line_in,
  output logic fault_line_out,
  output logic fault_line_oe_b,
  // Analog comparator flags.
  input wire logic motor_supply_overvolt,
  input wire logic drain_source_overvolt,
  input wire logic regulator_overvolt_flag,
  // Gate outputs.
  output logic [2:0] gate_high_out,
  output logic [2:0] gate_low_out,
  output logic gate_hiz,
  // Working configuration.
  output pdpc_cfg_t cfg,
  // Serial programming port.
  input wire logic ser_write,
  input wire logic [2:0] ser_addr,
  input wire logic [7:0] ser_wdata,
  output logic [7:0] ser_rdata,
  output logic ser_busy,
  output logic serial_mode,
  output logic eeprom_error
);

  // Refuse write times that the eight-bit write counter cannot hold.
  if (EEP_WRITE_CYCLES < 1 || EEP_WRITE_CYCLES > 255) begin : g_bad_write_cycles
    $error("EEP_WRITE_CYCLES must be 1 to 255");
  end

  localparam int SYNC_W = 12;

  logic [SYNC_W-1:0] pin_raw;
  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;
  logic vcc_s;
  logic en_s;
  logic [2:0] hs_s;
  logic [2:0] ls_s;
  logic fault_s;
  logic mov_s;
  logic ds_s;
  logic reg_s;

  pdpc_mode_t mode;
  pdpc_mode_t next_mode;
  pdpc_rep_t rep;
  pdpc_rep_t next_rep;
  logic [7:0] work [NWORDS];
  logic [12:0] eep [NWORDS];
  logic [2:0] copy_idx;
  pdpc_dec_t copy_dec;
  logic [3:0] err_lat;
  logic [3:0] err_set;
  logic eof_ack;
  logic trip;
  logic gate_off;
  logic [PWM_W-1:0] pwm_cnt;
  logic [PWM_W-1:0] pwm_per;
  logic [PWM_W-1:0] pwm_hi;
  logic pwm_fall;
  logic ack;
  logic [PULSE_W-1:0] low_cnt;
  logic entry_ok;
  logic entry_cond;
  logic entry_hit;
  logic [7:0] wr_cnt;
  logic [2:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] ser_word;
  pdpc_dec_t ser_dec;
  logic next_fault_out;
  logic next_fault_oe_b;

  // Two-flop synchronisers for every asynchronous input.
  assign pin_raw = {logic_supply_pin, gate_enable_input, high_side_input, low_side_input,
                    fault_line_in, motor_supply_overvolt, drain_source_overvolt,
                    regulator_overvolt_flag};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
          sync_a[gi] <= 1'b0;
          sync_b[gi] <= 1'b0;
        end else begin
          sync_a[gi] <= pin_raw[gi];
          sync_b[gi] <= sync_a[gi];
        end
      end
    end
  endgenerate

  assign vcc_s = sync_b[11];
  assign en_s = sync_b[10];
  assign hs_s = sync_b[9:7];
  assign ls_s = sync_b[6:4];
  assign fault_s = sync_b[3];
  assign mov_s = sync_b[2];
  assign ds_s = sync_b[1];
  assign reg_s = sync_b[0];

  // Working configuration fields.
  assign cfg.crossover_delay = work[ADDR_TIMING][DLY_LSB +: 3];
  assign cfg.drain_source_threshold = work[ADDR_TIMING][THR_LSB +: 3];
  assign cfg.drain_source_blanking = work[ADDR_MONPWM][BLK_LSB +: 2];
  assign cfg.shunt_amp_gain = work[ADDR_MONPWM][GAIN_LSB +: 3];
  assign cfg.boost_reference_select = work[ADDR_MONPWM][BREF_BIT];
  assign cfg.fault_pwm_rate = work[ADDR_MONPWM][PWMR_BIT];
  assign cfg.gate_undervolt_compare_enable = work[ADDR_PROT][GUV_BIT];
  assign cfg.boost_pump_enable = work[ADDR_PROT][PUMP_BIT];
  assign cfg.drain_source_compare_enable = work[ADDR_PROT][DCMP_BIT];
  assign cfg.drain_source_trip_enable = work[ADDR_PROT][DTRIP_BIT];
  assign cfg.regulator_overvolt_trip_enable = work[ADDR_PROT][RTRIP_BIT];
  assign cfg.serial_port_enable = work[ADDR_IFACE][SPEN_BIT];

  // Error latches: a new event in the clearing cycle survives.
  assign copy_dec = pdpc_dec(eep[copy_idx]);
  always_comb begin
    err_set = 4'h0;
    err_set[ERR_MOV] = mov_s;
    err_set[ERR_DS] = ds_s & cfg.drain_source_compare_enable;
    err_set[ERR_REG] = reg_s;
    err_set[ERR_EEP] = (mode == PDPC_COPY) & copy_dec.ded;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      err_lat <= 4'h0;
    end else if (eof_ack || !vcc_s) begin
      err_lat <= err_set;
    end else begin
      err_lat <= err_lat | err_set;
    end
  end

  assign trip = err_lat[ERR_MOV]
              | (err_lat[ERR_DS] & cfg.drain_source_trip_enable)
              | (err_lat[ERR_REG] & cfg.regulator_overvolt_trip_enable);
  assign gate_off = trip | !vcc_s | !en_s | (mode != PDPC_NORMAL);

  // Gate outputs.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      gate_hiz <= 1'b1;
      gate_high_out <= 3'h0;
      gate_low_out <= 3'h0;
    end else begin
      gate_hiz <= gate_off;
      gate_high_out <= gate_off ? 3'h0 : hs_s;
      gate_low_out <= gate_off ? 3'h0 : ls_s;
    end
  end

  // Fault-line PWM and acknowledge sampling.
  assign pwm_per = cfg.fault_pwm_rate ? FAST_PER : SLOW_PER;
  always_comb begin
    if (rep == PDPC_EOF) begin
      pwm_hi = cfg.fault_pwm_rate ? FAST_EOF_HI : SLOW_EOF_HI;
    end else begin
      pwm_hi = cfg.fault_pwm_rate ? FAST_ERR_HI : SLOW_ERR_HI;
    end
  end
  assign pwm_fall = (rep != PDPC_IDLE) && (pwm_cnt == pwm_hi - 1'b1);
  assign ack = pwm_fall && !fault_s;
  assign eof_ack = ack && (rep == PDPC_EOF);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pwm_cnt <= '0;
    end else if (rep == PDPC_IDLE || ack || pwm_cnt >= pwm_per - 1'b1) begin
      pwm_cnt <= '0;
    end else begin
      pwm_cnt <= pwm_cnt + 1'b1;
    end
  end

  always_comb begin
    next_rep = rep;
    case (rep)
      PDPC_IDLE: begin
        if (err_lat != 4'h0 && vcc_s && mode == PDPC_NORMAL) begin
          next_rep = PDPC_ERR;
        end
      end
      PDPC_ERR: begin
        if (ack) begin
          next_rep = PDPC_EOF;
        end
      end
      PDPC_EOF: begin
        if (ack) begin
          next_rep = PDPC_IDLE;
        end
      end
      default: begin
        next_rep = PDPC_IDLE;
      end
    endcase
    if (!vcc_s) begin
      next_rep = PDPC_IDLE;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rep <= PDPC_IDLE;
    end else begin
      rep <= next_rep;
    end
  end

  // Serial entry pulse measurement.
  assign entry_cond = !en_s && (err_lat == 4'h0) && (rep == PDPC_IDLE)
                    && (hs_s == 3'h7) && (ls_s == 3'h0) && cfg.serial_port_enable;
  assign entry_hit = fault_s && (low_cnt >= ENTRY_MIN) && (low_cnt <= ENTRY_MAX)
                   && entry_ok && entry_cond;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      low_cnt <= '0;
      entry_ok <= 1'b0;
    end else if (fault_s || mode != PDPC_NORMAL) begin
      low_cnt <= '0;
      entry_ok <= 1'b1;
    end else begin
      low_cnt <= (low_cnt == PULSE_SAT) ? low_cnt : low_cnt + 1'b1;
      entry_ok <= entry_ok & entry_cond;
    end
  end

  // Mode sequence.
  always_comb begin
    next_mode = mode;
    case (mode)
      PDPC_COPY: begin
        if (copy_idx == 3'(NWORDS - 1)) begin
          next_mode = PDPC_NORMAL;
        end
      end
      PDPC_NORMAL: begin
        if (entry_hit) begin
          next_mode = PDPC_SERIAL;
        end
      end
      PDPC_SERIAL: begin
        if (en_s) begin
          next_mode = PDPC_FINISH;
        end
      end
      PDPC_FINISH: begin
        if (wr_cnt == 8'h00) begin
          next_mode = PDPC_COPY;
        end
      end
      default: begin
        next_mode = PDPC_COPY;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mode <= PDPC_COPY;
      serial_mode <= 1'b0;
    end else begin
      mode <= next_mode;
      serial_mode <= (next_mode == PDPC_SERIAL);
    end
  end

  // Copy of the store into the working registers.
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      copy_idx <= 3'h0;
      eeprom_error <= 1'b0;
      for (int i = 0; i < NWORDS; i++) begin
        work[i] <= WORD_RESET[i];
      end
    end else if (mode == PDPC_COPY) begin
      work[copy_idx] <= copy_dec.data;
      copy_idx <= (copy_idx == 3'(NWORDS - 1)) ? 3'h0 : copy_idx + 1'b1;
      eeprom_error <= (copy_idx == 3'h0) ? copy_dec.ded : (eeprom_error | copy_dec.ded);
    end
  end

  // Serial port: writes take EEP_WRITE_CYCLES before they land in the store.
  assign ser_dec = pdpc_dec(eep[ser_addr]);
  assign ser_word = ser_dec.data;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_cnt <= 8'h00;
      wr_addr <= 3'h0;
      wr_data <= 8'h00;
      ser_busy <= 1'b0;
      ser_rdata <= 8'h00;
      for (int i = 0; i < NWORDS; i++) begin
        eep[i] <= pdpc_enc(WORD_RESET[i]);
      end
    end else begin
      ser_rdata <= (ser_addr < 3'(NWORDS)) ? ser_word : 8'h00;
      if (wr_cnt != 8'h00) begin
        wr_cnt <= wr_cnt - 1'b1;
        ser_busy <= (wr_cnt != 8'h01);
        if (wr_cnt == 8'h01) begin
          eep[wr_addr] <= pdpc_enc(wr_data);
        end
      end else if (mode == PDPC_SERIAL && ser_write && ser_addr >= ADDR_TIMING
                   && ser_addr <= ADDR_IFACE) begin
        wr_cnt <= 8'(EEP_WRITE_CYCLES);
        wr_addr <= ser_addr;
        ser_busy <= 1'b1;
        wr_data <= (ser_wdata & ~FIXED_MASK[ser_addr]) | FIXED_VAL[ser_addr];
        if (ser_addr == ADDR_IFACE) begin
          wr_data[SPEN_BIT] <= ser_wdata[SPEN_BIT] & ser_word[SPEN_BIT];
        end
      end
    end
  end

  // Fault-line drive.
  always_comb begin
    next_fault_out = 1'b1;
    next_fault_oe_b = 1'b0;
    case (next_mode)
      PDPC_COPY, PDPC_FINISH: begin
        next_fault_out = 1'b0;
      end
      PDPC_SERIAL: begin
        next_fault_oe_b = 1'b1;
      end
      PDPC_NORMAL: begin
        if (!vcc_s) begin
          next_fault_out = 1'b0;
        end else if (next_rep != PDPC_IDLE) begin
          next_fault_out = (pwm_cnt < pwm_hi) && !ack;
        end
      end
      default: begin
        next_fault_out = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      fault_line_out <= 1'b0;
      fault_line_oe_b <= 1'b0;
    end else begin
      fault_line_out <= next_fault_out;
      fault_line_oe_b <= next_fault_oe_b;
    end
  end

endmodule

// >>> testbench/pdpc_mcu_model.sv
// Controller model on the fault wire of the protection block.
// Assumes a pulled-up wire that either party may pull low, clocked by sys_clk.
`timescale 1ns/1ps
module pdpc_mcu_model #(
  parameter int ACK_CYC = 120
) (
  // Clock.
  input wire logic sys_clk,
  // Device drive of the fault wire.
  input wire logic dev_out,
  input wire logic dev_oe_b,
  // Bench controls.
  input wire logic auto_ack,
  input wire logic hold_low,
  // Resolved wire level.
  output logic fault_wire
);
  int ack_cnt = 0;
  logic dev_was_high = 1'b1;
  // The wire is high unless the device or the controller pulls it low.
  assign fault_wire = !((!dev_oe_b && !dev_out) || hold_low || ack_cnt > 0);
  // A falling device drive starts a pull-down longer than one fast fault PWM period (100 clocks) but shorter than a slow one.
  always @(posedge sys_clk) begin
    dev_was_high <= dev_oe_b || dev_out;
    if (auto_ack && dev_was_high && !dev_oe_b && !dev_out) begin
      ack_cnt <= ACK_CYC;
    end else if (ack_cnt > 0) begin
      ack_cnt <= ack_cnt - 1;
    end
  end
endmodule

// >>> testbench/pdpc_top_asserts.sv
// Concurrent checks on the ports of the protection and configuration block.
// Assumes the single sys_clk domain with rst_b as asynchronous active-low reset.
`timescale 1ns/1ps
module pdpc_top_asserts
  import pdpc_pkg::*;
#(
  parameter int EEP_WRITE_CYCLES = 16
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst_b,
  // Pins and flags.
  input wire logic logic_supply_pin,
  input wire logic gate_enable_input,
  input wire logic [2:0] high_side_input,
  input wire logic [2:0] low_side_input,
  input wire logic motor_supply_overvolt,
  input wire logic drain_source_overvolt,
  input wire logic regulator_overvolt_flag,
  // Device outputs.
  input wire logic fault_line_out,
  input wire logic fault_line_oe_b,
  input wire logic [2:0] gate_high_out,
  input wire logic [2:0] gate_low_out,
  input wire logic gate_hiz,
  input wire pdpc_cfg_t cfg,
  // Serial port.
  input wire logic ser_write,
  input wire logic [2:0] ser_addr,
  input wire logic ser_busy,
  input wire logic serial_mode
);
  default clocking dcb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);
  localparam int WR_HOLD = EEP_WRITE_CYCLES - 1;

  write_time_a: assert property ($rose(ser_busy) |-> ##WR_HOLD ser_busy ##1 !ser_busy)
    else $error("Store write time wrong.");

  gates_off_a: assert property (gate_hiz |-> !gate_high_out && !gate_low_out)
    else $error("Gate driven while off.");
  mov_trip_a: assert property ($rose(motor_supply_overvolt) |-> ##[1:6] gate_hiz)
    else $error("Motor overvoltage did not stop gates.");
  ds_trip_a: assert property (
    $rose(drain_source_overvolt) && cfg.drain_source_compare_enable
    && cfg.drain_source_trip_enable |-> ##[1:6] gate_hiz)
    else $error("Drain-source trip missing.");
  ds_ignore_a: assert property (
    $rose(drain_source_overvolt) && !cfg.drain_source_compare_enable && !gate_hiz
    && gate_enable_input && logic_supply_pin && !motor_supply_overvolt
    && !regulator_overvolt_flag |=> (!gate_hiz) [*6])
    else $error("Ignored drain-source event stopped gates.");
  ds_report_a: assert property (
    $rose(drain_source_overvolt) && cfg.drain_source_compare_enable && !serial_mode
    |-> ##[1:150] !fault_line_out)
    else $error("Drain-source event not reported.");
  reg_trip_a: assert property (
    $rose(regulator_overvolt_flag) && cfg.regulator_overvolt_trip_enable |-> ##[1:6] gate_hiz)
    else $error("Regulator trip missing.");
  enable_low_a: assert property (!gate_enable_input [*5] |-> gate_hiz)
    else $error("Gates on with enable low.");
  supply_low_a: assert property (!logic_supply_pin [*5] |-> gate_hiz)
    else $error("Gates on with supply low.");
  entry_cond_a: assert property (
    $rose(serial_mode) |-> fault_line_oe_b && gate_hiz && !gate_enable_input
    && high_side_input == 3'h7 && low_side_input == 3'h0)
    else $error("Serial entry without its conditions.");
  copy_low_a: assert property (
    $fell(serial_mode) |-> ##1 (gate_hiz && !fault_line_oe_b && !fault_line_out) [*4])
    else $error("Fault line or gates free during copy.");
  reset_block_a: assert property ($rose(rst_b) |-> gate_hiz [*6])
    else $error("Gates free before reset copy.");
  write_busy_a: assert property (
    ser_write && serial_mode && !ser_busy && ser_addr inside {[3'h2:3'h5]} |=> ser_busy)
    else $error("Store write not started.");

  cover property ($rose(serial_mode));
  cover property ($fell(gate_hiz));
  cover property ($rose(ser_busy));
endmodule

bind pdpc_top pdpc_top_asserts #(.EEP_WRITE_CYCLES(EEP_WRITE_CYCLES)) u_asserts (.sys_clk,
  .rst_b, .logic_supply_pin, .gate_enable_input, .high_side_input, .low_side_input,
  .motor_supply_overvolt, .drain_source_overvolt, .regulator_overvolt_flag, .fault_line_out,
  .fault_line_oe_b, .gate_high_out, .gate_low_out, .gate_hiz, .cfg, .ser_write, .ser_addr,
  .ser_busy, .serial_mode);

// >>> testbench/pdpc_top_tb_top.sv
// Self-checking testbench of the protection and configuration block.
// Assumes the controller model on the fault wire and a 10 MHz sys_clk.
`timescale 1ns/1ps
module pdpc_top_tb_top;
  import pdpc_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic logic_supply_pin = 1'b1;
  logic gate_enable_input = 1'b0;
  logic [2:0] high_side_input = 3'h0;
  logic [2:0] low_side_input = 3'h0;
  logic motor_supply_overvolt = 1'b0;
  logic drain_source_overvolt = 1'b0;
  logic regulator_overvolt_flag = 1'b0;
  logic ser_write = 1'b0;
  logic [2:0] ser_addr = 3'h0;
  logic [7:0] ser_wdata = 8'h00;
  logic auto_ack = 1'b0;
  logic hold_low = 1'b0;
  logic fault_line_in, fault_line_out, fault_line_oe_b, gate_hiz, ser_busy, serial_mode;
  logic eeprom_error;
  logic [2:0] gate_high_out, gate_low_out;
  logic [7:0] ser_rdata;
  pdpc_cfg_t cfg;
  int n_fail = 0;
  int num_checks = 0;
  localparam pdpc_cfg_t CFG_DEF = '{3'h3, 3'h7, 2'h2, 3'h3, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1,
    1'b1, 1'b1, 1'b1};
  localparam logic [7:0] RST_W [8] = '{8'h00, 8'h00, 8'h67, 8'hA6, 8'hE0, 8'hC0, 8'h00, 8'h00};

  pdpc_top #(.EEP_WRITE_CYCLES(16)) dut (.sys_clk, .rst_b, .logic_supply_pin,
    .gate_enable_input, .high_side_input, .low_side_input, .fault_line_in, .fault_line_out,
    .fault_line_oe_b, .motor_supply_overvolt, .drain_source_overvolt, .regulator_overvolt_flag,
    .gate_high_out, .gate_low_out, .gate_hiz, .cfg, .ser_write, .ser_addr, .ser_wdata,
    .ser_rdata, .ser_busy, .serial_mode, .eeprom_error);
  pdpc_mcu_model mcu (.sys_clk, .dev_out(fault_line_out), .dev_oe_b(fault_line_oe_b),
    .auto_ack, .hold_low, .fault_wire(fault_line_in));

  initial forever #50 sys_clk = ~sys_clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic bound_ok(input logic ok);
    check(ok, 1'b1);
    if (!ok) begin
      tally_and_finish();
    end
  endtask

  task automatic wait_hiz(input logic v);
    for (int i = 0; i < 300 && gate_hiz !== v; i++) begin
      cyc(1);
    end
    bound_ok(gate_hiz === v);
  endtask

  task automatic flag(input int sel, input logic v);
    @(posedge sys_clk);
    case (sel)
      0: motor_supply_overvolt <= v;
      1: drain_source_overvolt <= v;
      default: regulator_overvolt_flag <= v;
    endcase
  endtask

  // Raises one flag, checks trip and report, then acknowledges the frame.
  task automatic ev(input int sel, input logic trip, input logic rep);
    logic seen;
    int hi;
    seen = 1'b0;
    hi = 0;
    flag(sel, 1'b1);
    cyc(8);
    flag(sel, 1'b0);
    for (int i = 0; i < 150; i++) begin
      cyc(1);
      seen = seen | !fault_line_in;
    end
    check(gate_hiz, trip);
    check(seen, rep);
    @(posedge sys_clk);
    auto_ack <= 1'b1;
    for (int i = 0; i < 3000 && hi < 300; i++) begin
      cyc(1);
      hi = fault_line_in ? hi + 1 : 0;
    end
    bound_ok(hi >= 300);
    @(posedge sys_clk);
    auto_ack <= 1'b0;
    cyc(1);
    check(gate_hiz, 1'b0);
  endtask

  task automatic enter(input int len);
    @(posedge sys_clk);
    gate_enable_input <= 1'b0;
    high_side_input <= 3'h7;
    low_side_input <= 3'h0;
    cyc(10);
    @(posedge sys_clk);
    hold_low <= 1'b1;
    cyc(len);
    @(posedge sys_clk);
    hold_low <= 1'b0;
    cyc(10);
  endtask

  task automatic wr_go(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    ser_write <= 1'b1;
    ser_addr <= a;
    ser_wdata <= d;
    @(posedge sys_clk);
    ser_write <= 1'b0;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d, input logic busy,
      input logic [7:0] rd);
    wr_go(a, d);
    cyc(1);
    check(ser_busy, busy);
    for (int i = 0; i < 300 && ser_busy !== 1'b0; i++) begin
      cyc(1);
    end
    bound_ok(ser_busy === 1'b0);
    cyc(2);
    check(ser_rdata, rd);
  endtask

  task automatic leave();
    @(posedge sys_clk);
    gate_enable_input <= 1'b1;
    for (int i = 0; i < 300 && serial_mode !== 1'b0; i++) begin
      cyc(1);
    end
    bound_ok(serial_mode === 1'b0);
    cyc(1);
    check(fault_line_in, 1'b0);
    check(gate_hiz, 1'b1);
    wait_hiz(1'b0);
    check(eeprom_error, 1'b0);
  endtask

  initial begin
    cyc(12);
    check(cfg, CFG_DEF);
    check(gate_hiz, 1'b1);
    @(posedge sys_clk);
    rst_b <= 1'b1;
    cyc(2);
    check(gate_hiz, 1'b1);
    check(eeprom_error, 1'b0);
    for (int a = 0; a < 8; a++) begin
      @(posedge sys_clk);
      ser_addr <= 3'(a);
      cyc(2);
      check(ser_rdata, RST_W[a]);
    end
    $display("Reset test done");
    @(posedge sys_clk);
    gate_enable_input <= 1'b1;
    high_side_input <= 3'h5;
    low_side_input <= 3'h2;
    wait_hiz(1'b0);
    cyc(1);
    check({gate_high_out, gate_low_out}, 6'h2A);
    for (int k = 0; k < 2; k++) begin
      @(posedge sys_clk);
      logic_supply_pin <= (k != 0);
      gate_enable_input <= (k == 0);
      cyc(5);
      check({gate_hiz, gate_high_out, gate_low_out}, 7'h40);
      @(posedge sys_clk);
      logic_supply_pin <= 1'b1;
      gate_enable_input <= 1'b1;
      wait_hiz(1'b0);
    end
    $display("Gate path test done");
    ev(0, 1'b1, 1'b1);
    ev(1, 1'b1, 1'b1);
    ev(2, 1'b1, 1'b1);
    $display("Default protection test done");
    wr(3'h4, 8'h00, 1'b0, 8'hE0);
    enter(1000);
    check(serial_mode, 1'b0);
    enter(3000);
    check(serial_mode, 1'b1);
    wr(3'h1, 8'hFF, 1'b0, 8'h00);
    wr(3'h4, 8'h20, 1'b1, 8'h20);
    leave();
    check({cfg.regulator_overvolt_trip_enable, cfg.drain_source_trip_enable,
      cfg.drain_source_compare_enable}, 3'h1);
    ev(1, 1'b0, 1'b1);
    ev(2, 1'b0, 1'b1);
    $display("Trip disable test done");
    enter(3000);
    check(serial_mode, 1'b1);
    wr(3'h4, 8'h00, 1'b1, 8'h00);
    wr_go(3'h5, 8'h00);
    leave();
    check({cfg.drain_source_compare_enable, cfg.serial_port_enable}, 2'h0);
    ev(1, 1'b0, 1'b0);
    enter(3000);
    check(serial_mode, 1'b0);
    $display("Compare disable and port lock test done");
    tally_and_finish();
  end
endmodule
